/* File: design/acc_ctrl.sv */
// conversion sequencing, output bus control and configuration port
module acc_ctrl
	import acc_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              resetn_in,
	// control pins from host
	input  wire logic              convert_trigger_n_in,
	input  wire logic              read_n_in,
	input  wire logic              chip_select_n_in,
	input  wire logic              reset_pin_in,
	input  wire logic              sleep_request_in,
	// mode straps
	input  wire logic              port_style_sel_in,
	input  wire logic              cfg_source_sel_in,
	input  wire logic              serial_clock_source_sel_in,
	input  wire logic              read_during_convert_sel_in,
	input  wire logic              bipolar_sel_in,
	input  wire logic              range_span_sel_in,
	// configuration port
	input  wire logic              cfg_port_select_n_in,
	input  wire logic              cfg_serial_in,
	input  wire logic              cfg_serial_clock_in,
	// converter core
	input  wire logic [DATA_W-1:0] sar_result_in,
	output logic                   sample_hold_out,
	output acc_range_type          range_code_out,
	output logic                   sleep_active_out,
	// status and result
	output logic                   busy_out,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe_n_out,
	output logic                   result_bit_13_out,
	output logic                   result_bit_13_oe_n_out,
	output logic                   output_coding_sel_out,
	output logic [CFG_W-1:0]       cfg_word_out,
	output logic                   cfg_port_enable_out
);

	// ****************************************************
	// input synchronisation
	// ****************************************************
	acc_pins_type pins_raw;
	acc_pins_type pins;

	always_comb
	begin
		pins_raw.convert_trigger_n       = convert_trigger_n_in;
		pins_raw.read_n                  = read_n_in;
		pins_raw.chip_select_n           = chip_select_n_in;
		pins_raw.reset_pin               = reset_pin_in;
		pins_raw.sleep_request           = sleep_request_in;
		pins_raw.port_style_sel          = port_style_sel_in;
		pins_raw.cfg_source_sel          = cfg_source_sel_in;
		pins_raw.serial_clock_source_sel = serial_clock_source_sel_in;
		pins_raw.read_during_convert_sel = read_during_convert_sel_in;
		pins_raw.bipolar_sel             = bipolar_sel_in;
		pins_raw.range_span_sel          = range_span_sel_in;
		pins_raw.cfg_port_select_n       = cfg_port_select_n_in;
		pins_raw.cfg_serial_in           = cfg_serial_in;
		pins_raw.cfg_serial_clock        = cfg_serial_clock_in;
	end

	acc_sync u_sync
	(
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.pins_in    (pins_raw),
		.pins_out   (pins)
	); // R16

	// ****************************************************
	// edge detection
	// ****************************************************
	acc_pins_type pins_q;
	logic         trig_fall;
	logic         reset_fall;
	logic         sclk_rise;

	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
			pins_q <= PIN_IDLE;
		else
			pins_q <= pins;
	end

	always_comb
	begin
		trig_fall  = pins_q.convert_trigger_n & ~pins.convert_trigger_n; // R1
		reset_fall = pins_q.reset_pin & ~pins.reset_pin; // R10
		sclk_rise  = ~pins_q.cfg_serial_clock & pins.cfg_serial_clock;
	end

	// ****************************************************
	// conversion sequencer
	// ****************************************************
	acc_state_type      state;
	acc_state_type      next_state;
	logic [CNT_W-1:0]   cnt;
	logic [CNT_W-1:0]   next_cnt;
	logic               next_busy;
	logic [DATA_W-1:0]  next_data;
	logic               master_rdc;
	logic               coding_twos;

	always_comb
	begin
		// master mode, internal clock, read after convert
		master_rdc  = pins.port_style_sel & ~pins.serial_clock_source_sel
		              & ~pins.read_during_convert_sel;
		coding_twos = cfg_word_out[CFG_CODING_BIT];
		next_state  = state;
		next_cnt    = cnt;
		next_data   = data_out;
		case (state)
			ST_IDLE:
			begin
				// sleeping refuses new work, busy refuses double starts
				if (trig_fall && !pins.sleep_request) // R12 R15
				begin
					next_state = ST_CONVERT; // R1
					next_cnt   = CNT_W'(CONV_CYCLES - 1);
				end
			end
			ST_CONVERT:
			begin
				// trigger edges here are simply not looked at
				if (cnt == '0) // R15
				begin
					next_data = coding_twos ? (sar_result_in ^ MSB_MASK)
					                        : sar_result_in;
					if (master_rdc) // R4
					begin
						next_state = ST_TRANSFER;
						next_cnt   = CNT_W'(XFER_CYCLES - 1);
					end
					else
						next_state = ST_IDLE;
				end
				else
					next_cnt = cnt - 1'b1;
			end
			ST_TRANSFER:
			begin
				if (cnt == '0)
					next_state = ST_IDLE;
				else
					next_cnt = cnt - 1'b1;
			end
			default:
				next_state = ST_IDLE;
		endcase
		// reset pin abandons work; its release clears the result
		if (pins.reset_pin) // R9
		begin
			next_state = ST_IDLE;
			next_cnt   = '0;
		end
		if (reset_fall) // R10
			next_data = DATA_ZERO;
		next_busy = (next_state != ST_IDLE); // R2
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			state    <= ST_IDLE;
			cnt      <= '0;
			busy_out <= 1'b0;
			data_out <= DATA_ZERO;
		end
		else
		begin
			state    <= next_state;
			cnt      <= next_cnt;
			busy_out <= next_busy;
			data_out <= next_data;
		end
	end

	// ****************************************************
	// configuration port and static outputs
	// ****************************************************
	logic [CFG_W-1:0] next_cfg;
	acc_range_type    next_range;

	always_comb
	begin
		// serial software mode with the shared pin taken low
		cfg_port_enable_out = pins.port_style_sel & ~pins.cfg_source_sel
		                      & ~pins.cfg_port_select_n; // R8
		next_cfg = cfg_word_out;
		if (cfg_port_enable_out && sclk_rise)
			next_cfg = {cfg_word_out[CFG_W-2:0], pins.cfg_serial_in}; // R14
		if (reset_fall)
			next_cfg = CFG_DEFAULT; // R11
		next_range = acc_range_type'({pins.bipolar_sel,
		                              pins.range_span_sel}); // R5
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			cfg_word_out   <= CFG_DEFAULT;
			range_code_out <= RANGE_UNI_5;
		end
		else
		begin
			cfg_word_out   <= next_cfg;
			range_code_out <= next_range;
		end
	end

	// bus enables stay live in sleep so the host can still read
	always_comb
	begin
		sample_hold_out        = (state == ST_CONVERT); // R1
		sleep_active_out       = pins.sleep_request & (state == ST_IDLE);
		output_coding_sel_out  = ~cfg_word_out[CFG_CODING_BIT]; // R10
		data_oe_n_out          = pins.chip_select_n | pins.read_n; // R6 R13
		result_bit_13_oe_n_out = data_oe_n_out | pins.port_style_sel; // R7
		result_bit_13_out      = data_out[SHARED_BIT]; // R7
	end

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);

	start_busy_a: assert property ( // R1
		(state == ST_IDLE && trig_fall && !pins.sleep_request
		 && !pins.reset_pin) |=> busy_out && sample_hold_out)
		else $error("trigger edge did not start a conversion");

	busy_span_a: assert property ( // R2
		(state != ST_IDLE && cnt != '0 && !pins.reset_pin) |=> busy_out)
		else $error("busy dropped too early");

	xfer_stretch_a: assert property ( // R4
		(state == ST_CONVERT && cnt == '0 && master_rdc
		 && !pins.reset_pin) |=> busy_out && !sample_hold_out)
		else $error("transfer did not stretch busy");

	range_map_a: assert property ( // R5
		##1 range_code_out == {$past(pins.bipolar_sel),
		                       $past(pins.range_span_sel)})
		else $error("range code does not follow selects");

	bus_drive_a: assert property ( // R6
		!data_oe_n_out |-> !pins.chip_select_n && !pins.read_n)
		else $error("bus driven without select and read");

	bit13_shared_a: assert property ( // R7
		!result_bit_13_oe_n_out |-> !pins.port_style_sel
		&& result_bit_13_out == data_out[SHARED_BIT])
		else $error("shared pin driven outside parallel mode");

	reset_abort_a: assert property ( // R9
		pins.reset_pin |=> !busy_out)
		else $error("conversion survived reset pin");

	reset_clear_a: assert property ( // R10 R11
		reset_fall |=> data_out == DATA_ZERO
		&& cfg_word_out == CFG_DEFAULT && output_coding_sel_out)
		else $error("reset release did not clear outputs");

	sleep_refuse_a: assert property ( // R12
		(state == ST_IDLE && pins.sleep_request) |=> !busy_out)
		else $error("conversion started during sleep");

	busy_ignore_a: assert property ( // R15
		(state == ST_CONVERT && cnt > 1 && !pins.reset_pin)
		|=> cnt == $past(cnt) - 1'b1)
		else $error("trigger restarted a running conversion");

endmodule : acc_ctrl

/* File: design/acc_pkg.sv */
// constants, types and pin bundle of the converter control block
// How it works
// R1: falling convert trigger puts sampler into hold and starts a conversion.
// R2: busy rises at conversion start, falls once result is latched.
// R3: host may treat busy falling edge as result-ready strobe.
// R4: serial master read-after-convert mode stretches busy over the transfer.
// R5: bipolar and span selects pick 5V, 10V, +-5V or +-10V input range.
// R6: result bus driven only while chip select and read are both low.
// R7: in parallel mode the shared pin outputs result bit 13.
// R8: serial software mode: shared pin low enables the configuration port.
// R9: reset pin high holds the block reset and abandons any conversion.
// R10: reset pin falling edge zeroes data outputs, coding straight binary.
// R11: reset pin falling edge restores configuration register default.
// R12: sleep request lets running conversion finish, then refuses new ones.
// R13: digital interface keeps working during sleep.
// R14: host shifts configuration word in MSB first on configuration clock.
// R15: trigger edges while busy are ignored.
// R16: all pin inputs are synchronised before sequencing uses them.
package acc_pkg;

	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_CONV_NS     = 700;
	localparam int T_XFER_NS     = 560;
	// least times round up to whole cycles
	localparam int CONV_CYCLES   = (T_CONV_NS + CLK_PERIOD_NS - 1)
	                               / CLK_PERIOD_NS;
	localparam int XFER_CYCLES   = (T_XFER_NS + CLK_PERIOD_NS - 1)
	                               / CLK_PERIOD_NS;
	localparam int CNT_W         = 9;

	// ****************************************************
	// data and configuration
	// ****************************************************
	localparam int DATA_W         = 14;
	localparam int MSB_POS        = DATA_W - 1;
	localparam int SHARED_BIT     = 13;
	localparam int CFG_W          = 8;
	localparam int CFG_CODING_BIT = 0;
	localparam logic [CFG_W-1:0]  CFG_DEFAULT = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO   = 14'h0000;
	localparam logic [DATA_W-1:0] MSB_MASK    = 14'h2000;

	// ****************************************************
	// types
	// ****************************************************
	typedef enum logic [1:0]
	{
		RANGE_UNI_5  = 2'h0,
		RANGE_UNI_10 = 2'h1,
		RANGE_BI_5   = 2'h2,
		RANGE_BI_10  = 2'h3
	} acc_range_type;

	typedef enum {ST_IDLE, ST_CONVERT, ST_TRANSFER} acc_state_type;

	typedef struct packed
	{
		logic convert_trigger_n;
		logic read_n;
		logic chip_select_n;
		logic reset_pin;
		logic sleep_request;
		logic port_style_sel;
		logic cfg_source_sel;
		logic serial_clock_source_sel;
		logic read_during_convert_sel;
		logic bipolar_sel;
		logic range_span_sel;
		logic cfg_port_select_n;
		logic cfg_serial_in;
		logic cfg_serial_clock;
	} acc_pins_type;

	localparam int PIN_W = $bits(acc_pins_type);
	// idle levels: active-low strobes rest high
	localparam acc_pins_type PIN_IDLE = 14'h3804;

endpackage : acc_pkg

/* File: design/acc_sync.sv */
// two-flop synchroniser for the control pin bundle
module acc_sync
	import acc_pkg::*;
(
	// clock and reset
	input  wire logic         clk_sys_in,
	input  wire logic         resetn_in,
	// pins
	input  wire acc_pins_type pins_in,
	output acc_pins_type      pins_out
);

	acc_pins_type meta;
	acc_pins_type next_meta;
	acc_pins_type next_pins;

	always_comb
	begin
		next_meta = pins_in;
		next_pins = meta;
	end

	// first stage feeds only the second
	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			meta     <= PIN_IDLE;
			pins_out <= PIN_IDLE;
		end
		else
		begin
			meta     <= next_meta;
			pins_out <= next_pins;
		end
	end

endmodule : acc_sync

/* File: verif/acc_host.sv */
// host-side model that drives the control pins and waits on busy
module acc_host
	import acc_pkg::*;
(
	// clock and status
	input  wire logic    clk_sys_in,
	input  wire logic    busy_in,
	// pins
	output acc_pins_type pins_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial pins_out = PIN_IDLE;

	// ends just after an edge, so outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : tick

	task automatic drive(input acc_pins_type p);
		@(posedge clk_sys_in);
		pins_out <= p;
	endtask : drive

	// busy fall taken as result ready; len is edges busy stood high
	task automatic convert(input logic again, output int len);
		@(posedge clk_sys_in);
		pins_out.convert_trigger_n <= 1'b0;
		// busy answers on the third edge, so counting starts with it
		repeat (3) @(posedge clk_sys_in);
		pins_out.convert_trigger_n <= 1'b1;
		len = 0;
		while (len < 400)
		begin
			#1;
			if (busy_in !== 1'b1)
				break;
			len++;
			@(posedge clk_sys_in);
			// a stray trigger in mid-conversion
			if (again && len == 40)
				pins_out.convert_trigger_n <= 1'b0;
			if (again && len == 50)
				pins_out.convert_trigger_n <= 1'b1;
		end
	endtask : convert

	// slow config clock so each phase survives the synchroniser
	task automatic cfg_write(input logic [CFG_W-1:0] w);
		for (int i = CFG_W - 1; i >= 0; i--)
		begin
			@(posedge clk_sys_in);
			pins_out.cfg_serial_in <= w[i];
			repeat (4) @(posedge clk_sys_in);
			pins_out.cfg_serial_clock <= 1'b1;
			repeat (4) @(posedge clk_sys_in);
			pins_out.cfg_serial_clock <= 1'b0;
		end
		tick(4);
	endtask : cfg_write
endmodule : acc_host

/* File: verif/test_adc_conversion_control_pins.sv */
// self-checking bench for the converter control block
module test_adc_conversion_control_pins
	import acc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk_sys_in = 1'b0;
	logic              resetn_in  = 1'b0;
	logic [DATA_W-1:0] sar        = 14'h0a5c;
	logic [DATA_W-1:0] last;
	acc_pins_type      p          = PIN_IDLE;
	acc_pins_type      pins;
	logic              busy, hold, oe_n, b13, b13_oe_n, coding;
	logic              cfg_en, sleep_act;
	logic [DATA_W-1:0] dat;
	logic [CFG_W-1:0]  cfg;
	acc_range_type     rng;
	logic [1:0]        c;
	int                error_cnt   = 0;
	int                checks_done = 0;
	int                len;

	always #2 clk_sys_in = ~clk_sys_in;

	acc_host host (.clk_sys_in(clk_sys_in), .busy_in(busy), .pins_out(pins));

	acc_ctrl DUT (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.convert_trigger_n_in(pins.convert_trigger_n),
		.read_n_in(pins.read_n), .chip_select_n_in(pins.chip_select_n),
		.reset_pin_in(pins.reset_pin),
		.sleep_request_in(pins.sleep_request),
		.port_style_sel_in(pins.port_style_sel),
		.cfg_source_sel_in(pins.cfg_source_sel),
		.serial_clock_source_sel_in(pins.serial_clock_source_sel),
		.read_during_convert_sel_in(pins.read_during_convert_sel),
		.bipolar_sel_in(pins.bipolar_sel),
		.range_span_sel_in(pins.range_span_sel),
		.cfg_port_select_n_in(pins.cfg_port_select_n),
		.cfg_serial_in(pins.cfg_serial_in),
		.cfg_serial_clock_in(pins.cfg_serial_clock),
		.sar_result_in(sar), .sample_hold_out(hold),
		.range_code_out(rng), .sleep_active_out(sleep_act),
		.busy_out(busy), .data_out(dat), .data_oe_n_out(oe_n),
		.result_bit_13_out(b13), .result_bit_13_oe_n_out(b13_oe_n),
		.output_coding_sel_out(coding), .cfg_word_out(cfg),
		.cfg_port_enable_out(cfg_en));

	// ****************************************************
	// helpers
	// ****************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask : chk

	task automatic put(input int n);
		host.drive(p);
		host.tick(n);
	endtask : put

	task automatic summarize();
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic t_conv();
		host.convert(1'b0, len);
		chk(16'(len), 16'd175);
		chk(16'(dat), 16'h0a5c);
		chk(16'(oe_n), 16'h1);
		sar = 14'h3a5c;
		host.convert(1'b1, len);
		chk(16'(len), 16'd175);
		host.tick(12);
		chk(16'(busy), 16'h0);
		chk(16'(dat), 16'h3a5c);
	endtask : t_conv

	task automatic t_master();
		p.port_style_sel = 1'b1;
		p.chip_select_n = 1'b0;
		p.read_n = 1'b0;
		put(4);
		chk(16'(oe_n), 16'h0);
		chk(16'(b13_oe_n), 16'h1);
		host.convert(1'b0, len);
		chk(16'(len), 16'd315);
		p.read_during_convert_sel = 1'b1;
		put(4);
		host.convert(1'b0, len);
		chk(16'(len), 16'd175);
		p.port_style_sel = 1'b0;
		p.read_during_convert_sel = 1'b0;
		put(4);
	endtask : t_master

	task automatic t_range_read();
		for (int i = 0; i < 4; i++)
		begin
			c = 2'(i);
			p.bipolar_sel = c[1];
			p.range_span_sel = c[0];
			p.chip_select_n = c[1];
			p.read_n = c[0];
			put(4);
			chk(16'(rng), 16'(c));
			chk(16'(oe_n), 16'(c != 2'h0));
			chk(16'(b13_oe_n), 16'(c != 2'h0));
		end
		chk(16'(b13), 16'(sar[13]));
	endtask : t_range_read

	task automatic t_cfg();
		p.port_style_sel = 1'b1;
		p.serial_clock_source_sel = 1'b1;
		p.cfg_port_select_n = 1'b0;
		put(4);
		host.cfg_write(8'ha5);
		chk(16'(cfg), 16'h00a5);
		chk(16'(cfg_en), 16'h1);
		chk(16'(coding), 16'h0);
		host.convert(1'b0, len);
		chk(16'(len), 16'd175);
		last = sar ^ MSB_MASK;
		chk(16'(dat), 16'(last));
		p.cfg_source_sel = 1'b1;
		put(4);
		chk(16'(cfg_en), 16'h0);
	endtask : t_cfg

	task automatic t_reset();
		p.convert_trigger_n = 1'b0;
		put(20);
		chk(16'(busy), 16'h1);
		p.convert_trigger_n = 1'b1;
		p.reset_pin = 1'b1;
		put(6);
		chk(16'(busy), 16'h0);
		chk(16'(dat), 16'(last));
		p.reset_pin = 1'b0;
		put(6);
		chk(16'(dat), 16'h0);
		chk(16'(coding), 16'h1);
		chk(16'(cfg), 16'h0);
	endtask : t_reset

	task automatic t_sleep();
		p = PIN_IDLE;
		p.convert_trigger_n = 1'b0;
		put(6);
		chk(16'(hold), 16'h1);
		p.convert_trigger_n = 1'b1;
		p.sleep_request = 1'b1;
		put(2);
		for (int i = 0; i < 400 && busy === 1'b1; i++)
			host.tick(1);
		chk(16'(dat), 16'(sar));
		host.tick(4);
		chk(16'(sleep_act), 16'h1);
		host.convert(1'b0, len);
		chk(16'(len), 16'd0);
		p.chip_select_n = 1'b0;
		p.read_n = 1'b0;
		put(4);
		chk(16'(oe_n), 16'h0);
	endtask : t_sleep

	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		host.tick(2);
		t_conv();
		t_master();
		t_range_read();
		t_cfg();
		t_reset();
		t_sleep();
		summarize();
	end

	// whole run needs under 3000 cycles
	initial
	begin
		repeat (6000) @(posedge clk_sys_in);
		error_cnt++;
		summarize();
	end
endmodule : test_adc_conversion_control_pins
